/* File: hdl/alarm_pkg.sv */
// Constants and types for the alarm silence and isolate control block
// Operation
// R1: Fire LEDs steady while sounders disabled
// R2: Silence button toggles inside switch; disables sounders
// R3: Inside switch not disabled lets sounders run
// R4: Door closed, inside disabled: steady buzz, message
// R5: Outside key active: inside switch ignored
// R6: Outside key sensed via silence-trigger input
// R7: Outside on: sounders off, disablements LED
// R8: Outside on silences built-in buzzer
// R9: Outside on raises always-latched silence fault
// R10: Outside off: fault serviced, pending until acked
// R11: Outside off isolates active/acknowledged alarms
// R12: Isolated alarms take isolated state and label
// R13: Isolated alarm drives no LEDs, buzzer, outputs; the code still lights disable_led while any alarm is isolated
// R14: Every 30 s: charge off, check 18.9 V
// R15: Daily 60 min discharge test, check 24.4 V
// R16: Low-capacity fault serviced when test ends
// R17: Door closed, routing disabled: 2 s buzz
// R18: Acknowledged alarm keeps full alarm behaviour
// R19: Operator acknowledges displayed alarm only
// R20: Door closure is one rising synchronised event
package alarm_pkg;
	// ==========================================================
	// Types
	typedef enum logic [1:0] {AL_IDLE, AL_ACTIVE, AL_ACKED,
		AL_ISOLATED} alarm_st_t;
	typedef enum logic [1:0] {MSG_NONE, MSG_FIRE, MSG_SWITCH_LEFT,
		MSG_ROUTING_LEFT} msg_t;
	// ==========================================================
	// Sizes
	localparam int NUM_ALARMS = 8;
	localparam int IDX_W = 3;
	// ==========================================================
	// Register offsets
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_ALARMS = 12'h008;
	localparam logic [11:0] OFF_REENABLE = 12'h00C;
	localparam logic [11:0] OFF_FAULT_ACK = 12'h010;
	// ==========================================================
	// Control fields
	localparam int CTRL_RT_FIRE_DIS = 0;
	localparam int CTRL_RT_FAULT_DIS = 1;
	localparam int CTRL_FLT_LATCH = 2;
	localparam int CTRL_TRIG_LSB = 4;
	localparam int TRIG_W = 3;
	localparam logic [2:0] TRIG_SILENCE = 3'h2;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// ==========================================================
	// Fault bits and status fields
	localparam int FLT_SILENCE = 0;
	localparam int FLT_BATTERY = 1;
	localparam int FLT_LOWCAP = 2;
	localparam int ST_SERV_LSB = 4;
	localparam int ST_INSIDE = 8;
	localparam int ST_OUTSIDE = 9;
	localparam int ST_MSG_LSB = 10;
	localparam int ST_TEST = 12;
	localparam int ST_UNIT_LSB = 16;
	// ==========================================================
	// Timing and thresholds
	localparam int CLK_HZ = 125_000_000;
	localparam int SEC_CYCLES = CLK_HZ * 1;
	localparam int ROUTE_BUZZ_S = 2;
	localparam int ROUTE_BUZZ_CYCLES = ROUTE_BUZZ_S * CLK_HZ;
	localparam int BATT_CHECK_S = 30;
	localparam int BATT_TEST_MIN = 60;
	localparam int BATT_TEST_S = BATT_TEST_MIN * 60;
	localparam int BATT_PERIOD_H = 24;
	localparam int BATT_PERIOD_S = BATT_PERIOD_H * 3600;
	localparam logic [15:0] BATT_MIN_MV = 16'd18900;
	localparam logic [15:0] LOWCAP_MIN_MV = 16'd24400;
	localparam logic [7:0] UNIT_NUMBER = 8'h01;
endpackage : alarm_pkg

/* File: hdl/alarm_slot.sv */
// One fire alarm entry and its state
`timescale 1ns/100ps
module alarm_slot
	import alarm_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Events
	input wire logic raise,
	input wire logic ack,
	input wire logic isolate,
	input wire logic reenable,
	// State
	output alarm_st_t state
);
	alarm_st_t state_ff;
	alarm_st_t nxt_state;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			AL_IDLE: begin
				if (raise) begin
					nxt_state = AL_ACTIVE;
				end
			end
			AL_ACTIVE: begin
				if (isolate) begin
					nxt_state = AL_ISOLATED; // R11 R12
				end else if (ack) begin
					nxt_state = AL_ACKED; // R18
				end
			end
			AL_ACKED: begin
				if (isolate) begin
					nxt_state = AL_ISOLATED; // R11 R12
				end
			end
			default: begin
				if (reenable) begin
					nxt_state = AL_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= AL_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign state = state_ff;
endmodule : alarm_slot

/* File: hdl/alarm_ctrl.sv */
// Silence switches, alarm isolation, door warnings and battery tests
`timescale 1ns/100ps
module alarm_ctrl
	import alarm_pkg::*;
#(
	parameter int SEC_CYC = SEC_CYCLES,
	parameter int BUZZ_CYC = ROUTE_BUZZ_CYCLES
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Front panel and sensors
	input wire logic silence_sounders_button,
	input wire logic ack_button,
	input wire logic [IDX_W-1:0] shown_alarm,
	input wire logic prog_in,
	input wire logic door_closed,
	input wire logic [NUM_ALARMS-1:0] alarm_raise,
	input wire logic [15:0] batt_mv,
	// Indicators and outputs
	output logic fire_led,
	output logic disable_led,
	output logic buzzer,
	output logic sounder_out,
	output logic prog_out,
	output logic routing_out,
	output logic charge_en,
	output logic [1:0] message
);
	// ==========================================================
	// Declarations
	logic [31:0] ctrl_ff;
	logic pready_ff, pslverr_ff;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_rdata;
	logic nxt_err;
	logic acc_done, wr_done;
	logic btn_ff, outside_ff, inside_dis_ff;
	logic door_s1_ff, door_s2_ff, door_s3_ff;
	logic door_rise, outside_now, btn_rise, out_rise, out_fall;
	logic [NUM_ALARMS-1:0] reen_ff;
	alarm_st_t st [NUM_ALARMS];
	logic [NUM_ALARMS-1:0] act_v, iso_v;
	logic [2*NUM_ALARMS-1:0] st_flat;
	logic any_act, any_iso, rt_dis;
	logic [2:0] flt_pend_ff, flt_serv_ff, flt_ack;
	logic sw_left_ff;
	logic [27:0] buzz_cnt_ff;
	logic [26:0] tick_cnt_ff;
	logic tick, blink_ff;
	logic [4:0] sec30_ff;
	logic chk_ff;
	logic [16:0] day_ff;
	logic test_win;
	logic fire_led_ff, disable_led_ff, buzzer_ff, sounder_ff;
	logic prog_ff, routing_ff, charge_ff;
	msg_t msg_ff, nxt_msg;

	// ==========================================================
	// APB slave
	assign acc_done = psel && penable && pready_ff;
	assign wr_done = acc_done && pwrite;

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		nxt_err = 1'b0;
		if (paddr == OFF_CTRL) begin
			nxt_rdata = ctrl_ff;
		end else if (paddr == OFF_STATUS) begin
			nxt_rdata[2:0] = flt_pend_ff;
			nxt_rdata[ST_SERV_LSB +: 3] = flt_serv_ff;
			nxt_rdata[ST_INSIDE] = inside_dis_ff;
			nxt_rdata[ST_OUTSIDE] = outside_ff;
			nxt_rdata[ST_MSG_LSB +: 2] = msg_ff;
			nxt_rdata[ST_TEST] = test_win;
			nxt_rdata[ST_UNIT_LSB +: 8] = UNIT_NUMBER;
		end else if (paddr == OFF_ALARMS) begin
			nxt_rdata[2*NUM_ALARMS-1:0] = st_flat;
		end else if (paddr == OFF_REENABLE) begin
			nxt_rdata = 32'h0000_0000;
		end else if (paddr == OFF_FAULT_ACK) begin
			nxt_rdata = 32'h0000_0000;
		end else begin
			nxt_err = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff <= psel && penable && !pready_ff;
			if (psel && penable && !pready_ff) begin
				prdata_ff <= pwrite ? 32'h0000_0000 : nxt_rdata;
				pslverr_ff <= nxt_err;
			end else begin
				pslverr_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= CTRL_RESET;
			reen_ff <= '0;
		end else begin
			reen_ff <= '0;
			if (wr_done && paddr == OFF_CTRL) begin
				ctrl_ff <= pwdata;
			end
			if (wr_done && paddr == OFF_REENABLE) begin
				reen_ff <= pwdata[NUM_ALARMS-1:0];
			end
		end
	end
	assign flt_ack = (wr_done && paddr == OFF_FAULT_ACK) ?
		pwdata[2:0] : 3'h0;

	// ==========================================================
	// Switch and door sensing
	assign outside_now = prog_in &&
		ctrl_ff[CTRL_TRIG_LSB +: TRIG_W] == TRIG_SILENCE; // R6
	assign btn_rise = silence_sounders_button && !btn_ff;
	assign out_rise = outside_now && !outside_ff;
	assign out_fall = !outside_now && outside_ff;
	assign door_rise = door_s2_ff && !door_s3_ff; // R20

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			btn_ff <= 1'b0;
			outside_ff <= 1'b0;
			inside_dis_ff <= 1'b0;
			door_s1_ff <= 1'b0;
			door_s2_ff <= 1'b0;
			door_s3_ff <= 1'b0;
		end else begin
			btn_ff <= silence_sounders_button;
			outside_ff <= outside_now;
			door_s1_ff <= door_closed;
			door_s2_ff <= door_s1_ff;
			door_s3_ff <= door_s2_ff;
			if (btn_rise && !outside_ff) begin
				inside_dis_ff <= !inside_dis_ff; // R2 R5
			end
		end
	end

	// ==========================================================
	// Alarm entries
	genvar gi;
	generate
		for (gi = 0; gi < NUM_ALARMS; gi++) begin : g_slot
			alarm_slot u_slot (
				.pclk(pclk),
				.presetn(presetn),
				.raise(alarm_raise[gi]),
				.ack(ack_button && shown_alarm == IDX_W'(gi)), // R19
				.isolate(out_fall), // R11
				.reenable(reen_ff[gi]),
				.state(st[gi])
			);
			assign act_v[gi] = st[gi] == AL_ACTIVE ||
				st[gi] == AL_ACKED; // R18 R13
			assign iso_v[gi] = st[gi] == AL_ISOLATED; // R12
			assign st_flat[2*gi +: 2] = st[gi];
		end
	endgenerate
	assign any_act = |act_v;
	assign any_iso = |iso_v;
	assign rt_dis = ctrl_ff[CTRL_RT_FIRE_DIS] ||
		ctrl_ff[CTRL_RT_FAULT_DIS];

	// ==========================================================
	// Door warnings
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_left_ff <= 1'b0;
			buzz_cnt_ff <= '0;
		end else begin
			if (door_rise && inside_dis_ff && !outside_ff) begin
				sw_left_ff <= 1'b1; // R4
			end else if (!inside_dis_ff || outside_ff || !door_s2_ff) begin
				sw_left_ff <= 1'b0;
			end
			if (door_rise && rt_dis) begin
				buzz_cnt_ff <= BUZZ_CYC[27:0]; // R17
			end else if (buzz_cnt_ff != '0) begin
				buzz_cnt_ff <= buzz_cnt_ff - 28'h1;
			end
		end
	end

	always_comb begin
		nxt_msg = MSG_NONE;
		if (any_act) begin
			nxt_msg = MSG_FIRE;
		end else if (sw_left_ff) begin
			nxt_msg = MSG_SWITCH_LEFT; // R4
		end else if (buzz_cnt_ff != '0) begin
			nxt_msg = MSG_ROUTING_LEFT; // R17
		end
	end

	// ==========================================================
	// Seconds timebase and battery tests
	assign tick = tick_cnt_ff == 27'(SEC_CYC - 1);
	assign test_win = day_ff >= 17'(BATT_PERIOD_S - BATT_TEST_S);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_ff <= '0;
			blink_ff <= 1'b0;
			sec30_ff <= '0;
			chk_ff <= 1'b0;
			day_ff <= '0;
		end else begin
			tick_cnt_ff <= tick ? 27'h0 : tick_cnt_ff + 27'h1;
			if (tick) begin
				blink_ff <= !blink_ff;
				if (sec30_ff == 5'(BATT_CHECK_S - 1)) begin
					sec30_ff <= '0;
				end else begin
					sec30_ff <= sec30_ff + 5'h1;
				end
				chk_ff <= sec30_ff == 5'(BATT_CHECK_S - 2); // R14
				if (day_ff == 17'(BATT_PERIOD_S - 1)) begin
					day_ff <= '0;
				end else begin
					day_ff <= day_ff + 17'h1;
				end
			end
		end
	end

	// ==========================================================
	// Faults
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flt_pend_ff <= 3'h0;
			flt_serv_ff <= 3'h0;
		end else begin
			if (out_rise) begin
				flt_pend_ff[FLT_SILENCE] <= 1'b1; // R9
				flt_serv_ff[FLT_SILENCE] <= 1'b0;
			end else if (out_fall && flt_pend_ff[FLT_SILENCE]) begin
				flt_serv_ff[FLT_SILENCE] <= 1'b1; // R10
			end else if (flt_ack[FLT_SILENCE] &&
				flt_serv_ff[FLT_SILENCE]) begin
				flt_pend_ff[FLT_SILENCE] <= 1'b0; // R10
				flt_serv_ff[FLT_SILENCE] <= 1'b0;
			end
			if (tick && chk_ff && batt_mv < BATT_MIN_MV) begin
				flt_pend_ff[FLT_BATTERY] <= 1'b1; // R14
			end else if (flt_ack[FLT_BATTERY] || (tick && chk_ff &&
				!ctrl_ff[CTRL_FLT_LATCH])) begin
				flt_pend_ff[FLT_BATTERY] <= 1'b0;
			end
			if (tick && day_ff == 17'(BATT_PERIOD_S - 1) &&
				(flt_pend_ff[FLT_LOWCAP] || batt_mv < LOWCAP_MIN_MV)) begin
				flt_pend_ff[FLT_LOWCAP] <= 1'b1; // R15
				flt_serv_ff[FLT_LOWCAP] <= 1'b1; // R16
			end else if (tick && test_win && batt_mv < LOWCAP_MIN_MV) begin
				flt_pend_ff[FLT_LOWCAP] <= 1'b1; // R15
				flt_serv_ff[FLT_LOWCAP] <= 1'b0;
			end else if (flt_ack[FLT_LOWCAP]) begin
				flt_pend_ff[FLT_LOWCAP] <= 1'b0;
				flt_serv_ff[FLT_LOWCAP] <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Output drivers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fire_led_ff <= 1'b0;
			disable_led_ff <= 1'b0;
			buzzer_ff <= 1'b0;
			sounder_ff <= 1'b0;
			prog_ff <= 1'b0;
			routing_ff <= 1'b0;
			charge_ff <= 1'b0;
			msg_ff <= MSG_NONE;
		end else begin
			fire_led_ff <= any_act && (outside_ff || inside_dis_ff ||
				blink_ff); // R1 R13
			disable_led_ff <= outside_ff || inside_dis_ff || any_iso ||
				rt_dis; // R7 R11
			buzzer_ff <= !outside_ff && (any_act || sw_left_ff ||
				buzz_cnt_ff != '0); // R8 R4 R17
			sounder_ff <= any_act && !outside_ff &&
				!inside_dis_ff; // R2 R3 R5 R7
			prog_ff <= any_act; // R13
			routing_ff <= any_act &&
				!ctrl_ff[CTRL_RT_FIRE_DIS]; // R13
			charge_ff <= !chk_ff && !test_win; // R14 R15
			msg_ff <= nxt_msg;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign fire_led = fire_led_ff;
	assign disable_led = disable_led_ff;
	assign buzzer = buzzer_ff;
	assign sounder_out = sounder_ff;
	assign prog_out = prog_ff;
	assign routing_out = routing_ff;
	assign charge_en = charge_ff;
	assign message = msg_ff;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sounder_block_a: assert property ( // R2
		(outside_ff || inside_dis_ff) |=> !sounder_out)
		else $error("sounders active while disabled");
	sounder_run_a: assert property ( // R3
		(any_act && !outside_ff && !inside_dis_ff) |=> sounder_out)
		else $error("sounder not run");
	inside_ignore_a: assert property ( // R5
		(outside_ff && btn_rise) |=> $stable(inside_dis_ff))
		else $error("inside toggled");
	outside_led_a: assert property ( // R7
		out_rise |=> ##1 disable_led)
		else $error("disablements LED off");
	outside_mute_a: assert property ( // R8
		outside_ff |=> !buzzer)
		else $error("buzzer on with outside key");
	silence_fault_a: assert property ( // R9
		out_rise |=> flt_pend_ff[FLT_SILENCE] && !flt_serv_ff[FLT_SILENCE])
		else $error("silence fault not raised");
	isolate_all_a: assert property ( // R11
		out_fall |=> (iso_v & $past(act_v)) == $past(act_v))
		else $error("alarm left active");
	isolated_dark_a: assert property ( // R13
		!any_act |=> !fire_led && !routing_out && !prog_out)
		else $error("output for no alarm");
	steady_led_a: assert property ( // R1
		(any_act && inside_dis_ff) [*2] |=> fire_led)
		else $error("fire LED blinks");
	route_buzz_a: assert property ( // R17
		(door_rise && rt_dis && !outside_ff && !inside_dis_ff) |=> ##1
		buzzer && message == MSG_ROUTING_LEFT || message == MSG_FIRE)
		else $error("no routing warning");

	isolate_c: cover property (out_rise ##[1:50] out_fall);
	switch_left_c: cover property (door_rise && inside_dis_ff);
	ack_c: cover property (ack_button && any_act);
endmodule : alarm_ctrl

/* File: verification/panel_model.sv */
// Front panel operator switches and door sensor model
`timescale 1ns/100ps
module panel_model
	import alarm_pkg::*;
(
	// Clock
	input wire logic pclk,
	// Panel lines
	output logic silence_sounders_button,
	output logic ack_button,
	output logic [IDX_W-1:0] shown_alarm,
	output logic prog_in,
	output logic door_closed
);
	initial begin
		silence_sounders_button = 1'h0;
		ack_button = 1'h0;
		shown_alarm = '0;
		prog_in = 1'h0;
		door_closed = 1'h0;
	end
	// ==========================================================
	// Operator actions
	task automatic press();
		@(posedge pclk) silence_sounders_button <= 1'h1;
		@(posedge pclk) silence_sounders_button <= 1'h0;
	endtask : press
	task automatic ack(input logic [IDX_W-1:0] idx);
		@(posedge pclk) shown_alarm <= idx;
		@(posedge pclk) ack_button <= 1'h1;
		@(posedge pclk) ack_button <= 1'h0;
	endtask : ack
	task automatic key(input logic v);
		@(posedge pclk) prog_in <= v;
	endtask : key
	task automatic door(input logic v);
		@(posedge pclk) door_closed <= v;
	endtask : door
endmodule : panel_model

/* File: verification/testbench.sv */
// Self-checking testbench for the alarm silence and isolate control
`timescale 1ns/100ps
module testbench;
	import alarm_pkg::*;
	localparam int SEC = 1;
	localparam int BZ = 20;
	localparam logic [31:0] TRIG = 32'(TRIG_SILENCE) << CTRL_TRIG_LSB;
	localparam logic [31:0] B_SIL = 32'h1 << FLT_SILENCE;
	localparam logic [31:0] B_BAT = 32'h1 << FLT_BATTERY;
	localparam logic [31:0] B_LOW = 32'h1 << FLT_LOWCAP;
	localparam logic [31:0] B_SRV = 32'h1 << ST_SERV_LSB;
	localparam logic [31:0] B_IN = 32'h1 << ST_INSIDE;
	localparam logic [31:0] B_OUT = 32'h1 << ST_OUTSIDE;
	localparam logic [31:0] B_TST = 32'h1 << ST_TEST;
	logic pclk, presetn, psel, penable;
	logic pwrite, pready, pslverr, button, ackb, prog_in, door;
	logic fire_led, disable_led, buzzer, sounder_out, prog_out;
	logic routing_out, charge_en;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [IDX_W-1:0] shown;
	logic [NUM_ALARMS-1:0] raise;
	logic [15:0] batt_mv;
	logic [1:0] message;
	logic [64:0] exp_q[$];
	logic [64:0] ex;
	int err_total = 0, n_tests = 0, seed = 54912, cyc = 0, ai, aj, n, k;

	initial begin
		pclk = 1'h0;
		forever #4 pclk = ~pclk;
	end

	alarm_ctrl #(.SEC_CYC(SEC), .BUZZ_CYC(BZ)) DUT (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .silence_sounders_button(button),
		.ack_button(ackb), .shown_alarm(shown), .prog_in(prog_in),
		.door_closed(door), .alarm_raise(raise), .batt_mv(batt_mv),
		.fire_led(fire_led), .disable_led(disable_led), .buzzer(buzzer),
		.sounder_out(sounder_out), .prog_out(prog_out),
		.routing_out(routing_out), .charge_en(charge_en), .message(message));

	panel_model panel (.pclk(pclk), .silence_sounders_button(button),
		.ack_button(ackb), .shown_alarm(shown), .prog_in(prog_in),
		.door_closed(door));

	// ==========================================================
	// Checking and reporting
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 100000) begin
			err_total++;
			tally_and_finish();
		end
		if (psel && penable && pready && !pwrite) begin
			ex = exp_q.pop_front();
			chk("prdata", ex[31:0], prdata & ex[63:32]);
			chk("pslverr", 32'(ex[64]), 32'(pslverr));
		end
	end

	// ==========================================================
	// Bus and wait helpers
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] e, input logic er);
		exp_q.push_back({er, m, e & m});
		apb(1'h0, a, 32'h0000_0000);
	endtask : rd
	task automatic wt(input int c);
		repeat (c) @(posedge pclk);
	endtask : wt

	// ==========================================================
	// Main sequence
	initial begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		raise = 8'h00;
		batt_mv = 16'h61A8;
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		rd(OFF_CTRL, 32'hFFFF_FFFF, CTRL_RESET, 1'h0);
		rd(OFF_STATUS, 32'h00FF_0000, 32'(UNIT_NUMBER) << 16, 1'h0);
		rd(OFF_REENABLE, 32'hFFFF_FFFF, 32'h0000_0000, 1'h0);
		rd(12'h020, 32'hFFFF_FFFF, 32'h0000_0000, 1'h1);
		panel.key(1'h1);
		wt(4);
		rd(OFF_STATUS, B_OUT, 32'h0000_0000, 1'h0);
		panel.key(1'h0);
		panel.press();
		wt(3);
		rd(OFF_STATUS, B_IN, B_IN, 1'h0);
		panel.door(1'h1);
		wt(6);
		chk("message", 32'h2, 32'(message));
		wt(10);
		chk("buzzer", 32'h1, 32'(buzzer));
		panel.door(1'h0);
		panel.press();
		wt(3);
		rd(OFF_STATUS, B_IN, 32'h0000_0000, 1'h0);
		apb(1'h1, OFF_CTRL, TRIG | 32'h1);
		panel.door(1'h1);
		wt(6);
		chk("message", 32'h3, 32'(message));
		chk("buzzer", 32'h1, 32'(buzzer));
		wt(BZ + 4);
		chk("buzzer", 32'h0, 32'(buzzer));
		panel.door(1'h0);
		apb(1'h1, OFF_CTRL, TRIG);
		ai = {$random(seed)} % NUM_ALARMS;
		aj = (ai + 1) % NUM_ALARMS;
		@(posedge pclk);
		raise <= 8'(1 << ai) | 8'(1 << aj);
		@(posedge pclk);
		raise <= 8'h00;
		wt(4);
		chk("sounder_out", 32'h1, 32'(sounder_out));
		panel.ack(3'(ai));
		wt(3);
		rd(OFF_ALARMS, 32'hFFFF, 32'h2 << 2 * ai | 32'h1 << 2 * aj, 1'h0);
		chk("sounder_out", 32'h1, 32'(sounder_out));
		chk("routing_out", 32'h1, 32'(routing_out));
		chk("prog_out", 32'h1, 32'(prog_out));
		chk("message", 32'h1, 32'(message));
		panel.press();
		wt(4);
		chk("sounder_out", 32'h0, 32'(sounder_out));
		repeat (6) begin
			@(posedge pclk);
			chk("fire_led", 32'h1, 32'(fire_led));
		end
		panel.press();
		wt(4);
		chk("sounder_out", 32'h1, 32'(sounder_out));
		panel.key(1'h1);
		wt(4);
		chk("disable_led", 32'h1, 32'(disable_led));
		chk("sounder_out", 32'h0, 32'(sounder_out));
		chk("buzzer", 32'h0, 32'(buzzer));
		rd(OFF_STATUS, B_SIL | B_OUT, B_SIL | B_OUT, 1'h0);
		panel.press();
		wt(3);
		rd(OFF_STATUS, B_IN, 32'h0000_0000, 1'h0);
		panel.key(1'h0);
		wt(4);
		rd(OFF_ALARMS, 32'hFFFF, 32'h3 << 2 * ai | 32'h3 << 2 * aj, 1'h0);
		rd(OFF_STATUS, B_SIL | B_SRV, B_SIL | B_SRV, 1'h0);
		chk("disable_led", 32'h1, 32'(disable_led));
		repeat (4) begin
			@(posedge pclk);
			chk("outputs", 32'h0, 32'({fire_led, buzzer, sounder_out,
				prog_out, routing_out}));
		end
		apb(1'h1, OFF_FAULT_ACK, B_SIL);
		rd(OFF_STATUS, B_SIL, 32'h0000_0000, 1'h0);
		apb(1'h1, OFF_REENABLE, 32'h0000_00FF);
		rd(OFF_ALARMS, 32'hFFFF, 32'h0000_0000, 1'h0);
		batt_mv <= 16'({$random(seed)} % 18900);
		wt(2);
		n = 0;
		while (charge_en !== 1'h0 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		chk("charge_en", 32'h0, 32'(charge_en));
		wt(3);
		rd(OFF_STATUS, B_BAT, B_BAT, 1'h0);
		batt_mv <= 16'(18900 + {$random(seed)} % 5500);
		wt(35);
		rd(OFF_STATUS, B_BAT, 32'h0000_0000, 1'h0);
		n = 0;
		k = 0;
		while (k < 3 && n < 90000) begin
			@(posedge pclk);
			n++;
			k = charge_en ? 0 : k + 1;
		end
		wt(5);
		rd(OFF_STATUS, B_LOW | B_TST, B_LOW | B_TST, 1'h0);
		n = 0;
		while (charge_en !== 1'h1 && n < 4000) begin
			@(posedge pclk);
			n++;
		end
		wt(3);
		rd(OFF_STATUS, B_SRV << FLT_LOWCAP | B_TST, B_SRV << FLT_LOWCAP,
			1'h0);
		tally_and_finish();
	end
endmodule : testbench
